// [hw/hsm_pkg.sv]
// constants, types and state carriers for the haptic status and mode registers
package hsm_pkg;
	// register addresses
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_MODE = 8'h01;
	localparam logic [7:0] ADDR_FIRE = 8'h0c;
	// bus address of this device, arbitrary value
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h5a;
	// device kind reported in status bits 7-5, arbitrary value
	localparam logic [2:0] DEVICE_KIND = 3'h1;
	// status field positions
	localparam int ST_RESULT = 3;
	localparam int ST_FB = 2;
	localparam int ST_OT = 1;
	localparam int ST_OC = 0;
	localparam int ST_KIND_LO = 5;
	// mode field positions and reset values
	localparam int MD_RESET = 7;
	localparam int MD_STANDBY = 6;
	localparam int MD_MODE_LO = 0;
	localparam int FIRE_BIT = 0;
	localparam logic STANDBY_RST = 1'b1;
	localparam logic [2:0] MODE_RST = 3'h0;
	// playback mode codes
	localparam logic [2:0] MODE_INTERNAL = 3'h0;
	localparam logic [2:0] MODE_EDGE = 3'h1;
	localparam logic [2:0] MODE_DIAG = 3'h6;
	localparam logic [2:0] MODE_CAL = 3'h7;
	// timing
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned BEMF_ZERO_MS = 10;
	localparam int unsigned BEMF_ZERO_CYCLES = BEMF_ZERO_MS * 1000 * CLK_MHZ;
	localparam int unsigned RETRY_US = 1000;
	localparam int unsigned RETRY_CYCLES = RETRY_US * CLK_MHZ;
	localparam logic [2:0] RESET_CYCLES = 3'h4;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// serial bus slave states
	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_ADDR = 7'h02,
		S_ADDR_ACK = 7'h04,
		S_WR = 7'h08,
		S_WR_ACK = 7'h10,
		S_RD = 7'h20,
		S_RD_ACK = 7'h40
	} hsm_bus_e;
	// pins that arrive from outside the clock domain
	typedef struct packed {
		logic scl;
		logic sda;
		logic trig;
		logic overtemp;
		logic overcurrent;
	} hsm_pins_s;
	// events from on-chip logic on the same clock
	typedef struct packed {
		logic routine_done;
		logic routine_fail;
		logic lock_lost;
		logic bemf_zero;
		logic lra_mode;
	} hsm_event_s;
	// synchroniser state
	typedef struct packed {
		hsm_pins_s meta;
		hsm_pins_s q;
	} hsm_sync_s;
	// timer state
	typedef struct packed {
		logic [31:0] cnt;
		logic hit;
	} hsm_timer_s;
	// register bank and bus slave state
	typedef struct packed {
		hsm_bus_e st;
		logic [3:0] bits;
		logic [7:0] sh;
		logic rw;
		logic ack;
		logic [7:0] ptr;
		logic first;
		logic sda_oe;
		logic scl_q;
		logic sda_q;
		logic trig_q;
		logic f_result;
		logic f_fb;
		logic f_ot;
		logic f_oc;
		logic standby;
		logic [2:0] mode;
		logic go;
		logic [2:0] rst_cnt;
		logic abort;
		logic cancel;
		logic shutdown;
	} hsm_state_s;
endpackage : hsm_pkg

// [hw/hsm_sync.sv]
// two-stage synchroniser for the external pins
`timescale 1ns/100ps
module hsm_sync (
	input wire logic i_clk, // core clock
	input wire logic i_rst_n, // synchronous reset, active low
	input wire hsm_pkg::hsm_pins_s i_d, // raw pins
	output hsm_pkg::hsm_pins_s o_q // synchronised pins
);
	import hsm_pkg::*;

	hsm_sync_s r_reg;
	hsm_sync_s r_next;

	// first stage feeds only the second stage
	always_comb begin
		r_next.meta = i_d;
		r_next.q = r_reg.meta;
	end

	// state register, bus lines idle high
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			r_reg <= '{meta: '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
				q: '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0}};
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_q = r_reg.q;
endmodule : hsm_sync

// [hw/hsm_timer.sv]
// run-length timer: pulses after a condition has held for LIMIT cycles
`timescale 1ns/100ps
module hsm_timer #(
	parameter int unsigned LIMIT = 1
) (
	input wire logic i_clk, // core clock
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic i_run, // condition being timed
	output logic o_hit // one-cycle pulse each LIMIT cycles of i_run
);
	import hsm_pkg::*;

	hsm_timer_s r_reg;
	hsm_timer_s r_next;

	// count while running, restart on hit or when the condition drops
	always_comb begin
		r_next = r_reg;
		r_next.hit = 1'b0;
		if (!i_run) begin
			r_next.cnt = '0;
		end else if (r_reg.cnt == LIMIT - 1) begin
			r_next.cnt = '0;
			r_next.hit = 1'b1;
		end else begin
			r_next.cnt = r_reg.cnt + 32'h1;
		end
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_hit = r_reg.hit;
endmodule : hsm_timer

// [hw/hsm_regs.sv]
// status and mode registers of the haptic driver behind a two-wire bus slave
// How it works
// - diagnostic result flag reads 0 for a good actuator, 1 for any fault
// - rotating-mass mode: flag feedback timeout after back-EMF zero over 10 ms
// - resonant mode: flag feedback timeout whenever frequency lock is lost
// - reading status clears the feedback timeout flag
// - overtemperature shuts output down and latches status bit 1 until read
// - reading status clears the overtemperature flag
// - overcurrent latches status bit 0; it reads 0 while none occurred
// - low load impedance shuts output down and retries startup periodically
// - writing mode bit 7 aborts playback and restores every register default
// - the full reset bit clears itself once the reset has finished
// - mode bit 6 is software standby, 1 after reset
// - mode field bits 2-0 default 0: internal trigger, fire bit at 0x0c
// - mode field value 1 selects edge triggering from the trigger pin
// - result flag clears on read; valid once the fire bit has cleared
// - calibration: result 0 when converged, 1 when it failed
// - trigger rising edge sets fire; a second one before clear cancels
// - status register sits at address 0x00, before the mode register
`timescale 1ns/100ps
module hsm_regs #(
	parameter logic [6:0] DEV_ADDR = hsm_pkg::DEV_ADDR_DEFAULT,
	parameter int unsigned BEMF_CYCLES = hsm_pkg::BEMF_ZERO_CYCLES,
	parameter int unsigned RETRY_CYCLES = hsm_pkg::RETRY_CYCLES
) (
	input wire logic i_clk, // core clock, 250 MHz
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic i_scl, // bus clock pin
	input wire logic i_sda, // bus data pin level
	output logic o_sda_o, // bus data drive value, always low
	output logic o_sda_oe, // bus data drive enable, high pulls low
	input wire logic i_trigger_input_pin, // external trigger pin
	input wire logic i_overtemp, // die temperature above threshold
	input wire logic i_overcurrent, // load impedance below threshold
	input wire hsm_pkg::hsm_event_s i_ev, // events from on-chip logic
	output logic o_go, // fire bit, waveform running
	output logic o_cancel, // one-cycle waveform cancel
	output logic o_standby, // software standby
	output logic [2:0] o_mode, // playback mode field
	output logic o_playback_abort, // high while a full reset runs
	output logic o_shutdown, // output stage shut down
	output logic o_retry // one-cycle startup retry pulse
);
	import hsm_pkg::*;

	hsm_state_s r_reg;
	hsm_state_s r_next;
	hsm_pins_s pins_d;
	hsm_pins_s pins_s;
	logic bemf_hit;
	logic bemf_run;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// byte returned for a read at the given address
	function automatic logic [7:0] read_byte(input logic [7:0] a,
		input hsm_state_s s);
		logic [7:0] b;
		b = 8'h00;
		case (a)
			ADDR_STATUS: begin
				b[ST_KIND_LO +: 3] = DEVICE_KIND;
				b[ST_RESULT] = s.f_result;
				b[ST_FB] = s.f_fb;
				b[ST_OT] = s.f_ot;
				b[ST_OC] = s.f_oc;
			end
			ADDR_MODE: begin
				b[MD_RESET] = (s.rst_cnt != 3'h0);
				b[MD_STANDBY] = s.standby;
				b[MD_MODE_LO +: 3] = s.mode; // bits 5-3 stay zero
			end
			ADDR_FIRE: begin
				b[FIRE_BIT] = s.go;
			end
			default: begin
				b = 8'h00;
			end
		endcase
		return b;
	endfunction : read_byte

	// sticky flag: a set in the clearing cycle wins
	function automatic logic flag_next(input logic f, input logic set,
		input logic clr);
		return set | (f & ~clr);
	endfunction : flag_next

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and timers

	assign pins_d = '{scl: i_scl, sda: i_sda, trig: i_trigger_input_pin,
		overtemp: i_overtemp, overcurrent: i_overcurrent};

	hsm_sync u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_d(pins_d),
		.o_q(pins_s)
	);

	// back-EMF stuck at zero, only timed for the rotating-mass actuator
	assign bemf_run = i_ev.bemf_zero & ~i_ev.lra_mode;

	hsm_timer #(.LIMIT(BEMF_CYCLES)) u_bemf (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_run(bemf_run),
		.o_hit(bemf_hit)
	);

	// startup retry cadence while the load stays too low
	hsm_timer #(.LIMIT(RETRY_CYCLES)) u_retry (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_run(pins_s.overcurrent),
		.o_hit(o_retry)
	);

	////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		logic rise;
		logic fall;
		logic start;
		logic stop;
		logic load;
		logic clr_rd;
		logic wr_en;
		logic trig_edge;
		logic routine;
		trig_edge = pins_s.trig & ~r_reg.trig_q;
		routine = i_ev.routine_done &&
			(r_reg.mode == MODE_DIAG || r_reg.mode == MODE_CAL);
		rise = pins_s.scl & ~r_reg.scl_q;
		fall = ~pins_s.scl & r_reg.scl_q;
		start = pins_s.scl & r_reg.scl_q & r_reg.sda_q & ~pins_s.sda;
		stop = pins_s.scl & r_reg.scl_q & ~r_reg.sda_q & pins_s.sda;
		load = 1'b0;
		clr_rd = 1'b0;
		wr_en = 1'b0;
		r_next = r_reg;
		r_next.cancel = 1'b0;
		r_next.scl_q = pins_s.scl;
		r_next.sda_q = pins_s.sda;
		r_next.trig_q = pins_s.trig;

		// bus slave: address, pointer, write and read bytes
		case (r_reg.st)
			S_IDLE: begin
				r_next.sda_oe = 1'b0;
			end
			S_ADDR: begin
				if (rise) begin
					r_next.sh = {r_reg.sh[6:0], pins_s.sda};
					r_next.bits = r_reg.bits + 4'h1;
				end
				if (fall && r_reg.bits == BITS_PER_BYTE) begin
					if (r_reg.sh[7:1] == DEV_ADDR) begin
						r_next.st = S_ADDR_ACK;
						r_next.sda_oe = 1'b1;
						r_next.rw = r_reg.sh[0];
					end else begin
						r_next.st = S_IDLE;
					end
				end
			end
			S_ADDR_ACK: begin
				if (fall) begin
					r_next.bits = 4'h0;
					if (r_reg.rw) begin
						load = 1'b1;
						r_next.st = S_RD;
					end else begin
						r_next.sda_oe = 1'b0;
						r_next.first = 1'b1;
						r_next.st = S_WR;
					end
				end
			end
			S_WR: begin
				if (rise) begin
					r_next.sh = {r_reg.sh[6:0], pins_s.sda};
					r_next.bits = r_reg.bits + 4'h1;
				end
				if (fall && r_reg.bits == BITS_PER_BYTE) begin
					r_next.sda_oe = 1'b1;
					r_next.st = S_WR_ACK;
					if (r_reg.first) begin
						r_next.ptr = r_reg.sh;
						r_next.first = 1'b0;
					end else begin
						wr_en = 1'b1;
						r_next.ptr = r_reg.ptr + 8'h01;
					end
				end
			end
			S_WR_ACK: begin
				if (fall) begin
					r_next.sda_oe = 1'b0;
					r_next.bits = 4'h0;
					r_next.st = S_WR;
				end
			end
			S_RD: begin
				if (rise) begin
					r_next.bits = r_reg.bits + 4'h1;
				end
				if (fall) begin
					if (r_reg.bits == BITS_PER_BYTE) begin
						r_next.sda_oe = 1'b0;
						r_next.st = S_RD_ACK;
					end else begin
						r_next.sh = {r_reg.sh[6:0], 1'b0};
						r_next.sda_oe = ~r_reg.sh[6];
					end
				end
			end
			S_RD_ACK: begin
				if (rise) begin
					r_next.ack = ~pins_s.sda;
				end
				if (fall) begin
					r_next.bits = 4'h0;
					if (r_reg.ack) begin
						load = 1'b1;
						r_next.st = S_RD;
					end else begin
						r_next.st = S_IDLE;
					end
				end
			end
			default: begin
				r_next.st = S_IDLE;
				r_next.sda_oe = 1'b0;
			end
		endcase

		// load a read byte; reading status clears its sticky flags
		if (load) begin
			r_next.sh = read_byte(r_reg.ptr, r_reg);
			r_next.sda_oe = ~r_next.sh[7];
			r_next.ptr = r_reg.ptr + 8'h01;
			clr_rd = (r_reg.ptr == ADDR_STATUS);
		end

		// start and stop override any transfer in flight
		if (start) begin
			r_next.st = S_ADDR;
			r_next.bits = 4'h0;
			r_next.sda_oe = 1'b0;
		end else if (stop) begin
			r_next.st = S_IDLE;
			r_next.sda_oe = 1'b0;
		end

		// status flags
		r_next.f_ot = flag_next(r_reg.f_ot, pins_s.overtemp, clr_rd);
		r_next.f_oc = flag_next(r_reg.f_oc, pins_s.overcurrent,
			clr_rd);
		r_next.f_fb = flag_next(r_reg.f_fb,
			i_ev.lra_mode ? i_ev.lock_lost : bemf_hit, clr_rd);
		if (routine) begin
			r_next.f_result = i_ev.routine_fail;
		end else begin
			r_next.f_result = r_reg.f_result & ~clr_rd;
		end
		r_next.shutdown = pins_s.overtemp | pins_s.overcurrent;

		// fire bit: self-clears when the routine or waveform ends
		if (i_ev.routine_done) begin
			r_next.go = 1'b0;
		end
		if (r_reg.mode == MODE_EDGE && trig_edge) begin
			if (r_reg.go) begin
				r_next.go = 1'b0;
				r_next.cancel = 1'b1;
			end else begin
				r_next.go = 1'b1;
			end
		end

		// register writes
		if (wr_en && r_reg.ptr == ADDR_MODE) begin
			if (r_reg.sh[MD_RESET]) begin
				r_next.rst_cnt = RESET_CYCLES;
			end else begin
				r_next.standby = r_reg.sh[MD_STANDBY];
				r_next.mode = r_reg.sh[MD_MODE_LO +: 3];
			end
		end
		if (wr_en && r_reg.ptr == ADDR_FIRE) begin
			if (r_reg.sh[FIRE_BIT]) begin
				r_next.go = 1'b1;
			end else if (r_reg.go) begin
				r_next.go = 1'b0;
				r_next.cancel = 1'b1;
			end
		end

		// full reset: hold defaults until the count runs out
		if (r_reg.rst_cnt != 3'h0) begin
			r_next.rst_cnt = r_reg.rst_cnt - 3'h1;
			r_next.standby = STANDBY_RST;
			r_next.mode = MODE_RST;
			r_next.go = 1'b0;
			r_next.cancel = 1'b0;
			r_next.f_result = 1'b0;
			r_next.f_fb = 1'b0;
			r_next.f_ot = 1'b0;
			r_next.f_oc = 1'b0;
		end
		r_next.abort = (r_next.rst_cnt != 3'h0);
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			r_reg <= '0;
			r_reg.st <= S_IDLE;
			r_reg.scl_q <= 1'b1;
			r_reg.sda_q <= 1'b1;
			r_reg.standby <= STANDBY_RST;
			r_reg.mode <= MODE_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from the state register; the data drive value is tied low
	assign o_sda_o = 1'b0;
	assign o_sda_oe = r_reg.sda_oe;
	assign o_go = r_reg.go;
	assign o_cancel = r_reg.cancel;
	assign o_standby = r_reg.standby;
	assign o_mode = r_reg.mode;
	assign o_playback_abort = r_reg.abort;
	assign o_shutdown = r_reg.shutdown;
endmodule : hsm_regs

// [tb/hsm_asserts.sv]
// port checks for the haptic status and mode register block
`timescale 1ns/100ps
module hsm_asserts #(
	parameter logic [6:0] DEV_ADDR = 7'h5a,
	parameter int unsigned BEMF_CYCLES = 20,
	parameter int unsigned RETRY_CYCLES = 16
) (
	input wire logic i_clk, // core clock
	input wire logic i_rst_n, // reset, active low
	input wire logic i_overtemp, // hot die
	input wire logic i_overcurrent, // low load impedance
	input wire hsm_pkg::hsm_event_s i_ev, // on-chip events
	input wire logic o_go, // fire bit
	input wire logic o_cancel, // cancel pulse
	input wire logic o_standby, // standby bit
	input wire logic [2:0] o_mode, // mode field
	input wire logic o_playback_abort, // full reset running
	input wire logic o_shutdown, // output stage off
	input wire logic o_retry // restart attempt
);
	import hsm_pkg::*;
	////////////////////////////////////////////////////////////////////////
	// one clock domain for every check
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////////////////
	hot_shuts_out_a: assert property (i_overtemp [*4] |-> o_shutdown)
		else $error("no shutdown on overtemperature");
	low_load_off_a: assert property (i_overcurrent [*4] |-> o_shutdown)
		else $error("no shutdown on low load");
	shut_release_a: assert property
		((!i_overtemp && !i_overcurrent) [*4] |-> !o_shutdown)
		else $error("shutdown held without cause");
	retry_period_a: assert property
		(i_overcurrent [*8] |-> ##[0:24] (o_retry || !i_overcurrent))
		else $error("no restart attempt while overcurrent");
	retry_gap_a: assert property (o_retry |=> (!o_retry) [*8])
		else $error("restart attempts too close");
	retry_cause_a: assert property (o_retry |-> o_shutdown)
		else $error("restart attempt while running");
	cancel_ends_a: assert property
		(o_cancel |-> $past(o_go) && !o_go)
		else $error("cancel without a running waveform");
	done_clears_a: assert property (i_ev.routine_done |=> !o_go)
		else $error("fire bit held after routine end");
	abort_length_a: assert property
		($rose(o_playback_abort) |-> o_playback_abort [*4] ##1 !o_playback_abort)
		else $error("full reset length wrong");
	abort_default_a: assert property
		(o_playback_abort [*2] |-> !o_go && o_standby && o_mode == MODE_RST)
		else $error("defaults not restored by full reset");
	// main scenarios reached
	cover property ($rose(o_playback_abort));
	cover property (o_cancel);
	cover property (o_retry);
endmodule : hsm_asserts
bind hsm_regs hsm_asserts #(
	.DEV_ADDR(DEV_ADDR), .BEMF_CYCLES(BEMF_CYCLES),
	.RETRY_CYCLES(RETRY_CYCLES)
) u_chk (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_overtemp(i_overtemp),
	.i_overcurrent(i_overcurrent), .i_ev(i_ev), .o_go(o_go),
	.o_cancel(o_cancel), .o_standby(o_standby), .o_mode(o_mode),
	.o_playback_abort(o_playback_abort), .o_shutdown(o_shutdown),
	.o_retry(o_retry)
);

// [tb/hsm_host.sv]
// two-wire bus host model for the register slave
`timescale 1ns/100ps
module hsm_host #(
	parameter logic [6:0] ADR = 7'h5a
) (
	input wire logic i_clk, // core clock
	input wire logic i_sda_oe, // slave pulls data low
	output logic o_scl, // bus clock
	output logic o_sda // data wire level
);
	logic md; // host data drive, 1 releases
	// bus idles released with the clock high
	initial begin
		md = 1'b1;
		o_scl = 1'b1;
	end
	// wired-and data line with pull-up
	assign o_sda = md & ~i_sda_oe;
	////////////////////////////////////////////////////////////////////////
	// wait n edges, then step just past the edge
	task automatic cy(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : cy
	// one bit: drive b in low phase, sample wire in high phase
	task automatic bx(input logic b, output logic r);
		md = b;
		cy(4);
		o_scl = 1'b1;
		cy(4);
		r = o_sda;
		cy(4);
		o_scl = 1'b0;
		cy(4);
	endtask : bx
	// byte plus a released ninth bit; k low means acknowledged
	task automatic xb(input logic [7:0] d, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) bx(d[i], q[i]);
		bx(1'b1, k);
	endtask : xb
	// start or repeated start, data falls while clock high
	task automatic sta();
		md = 1'b1;
		cy(4);
		o_scl = 1'b1;
		cy(4);
		md = 1'b0;
		cy(4);
		o_scl = 1'b0;
		cy(4);
	endtask : sta
	// stop, data rises while clock high
	task automatic sto();
		md = 1'b0;
		cy(4);
		o_scl = 1'b1;
		cy(4);
		md = 1'b1;
		cy(4);
	endtask : sto
	// register write, nak set if any byte went unacknowledged
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
		logic [7:0] q;
		logic k0, k1, k2;
		sta();
		xb({ADR, 1'b0}, q, k0);
		xb(a, q, k1);
		xb(d, q, k2);
		sto();
		nak = k0 | k1 | k2;
	endtask : wr
	// register read of one byte, ended by a released acknowledge
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		logic k;
		sta();
		xb({ADR, 1'b0}, q, k);
		xb(a, q, k);
		sta();
		xb({ADR, 1'b1}, q, k);
		xb(8'hff, q, k);
		sto();
	endtask : rd
endmodule : hsm_host

// [tb/testbench.sv]
// self-checking bench for the haptic status and mode registers
`timescale 1ns/100ps
module testbench;
	import hsm_pkg::*;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] r;
	} hsm_row_s;
	logic i_clk;
	logic i_rst_n;
	logic trig;
	logic ot;
	logic oc;
	hsm_event_s ev;
	logic scl, sda, sda_o, sda_oe, go, cancel, standby, abort;
	logic shutdown, retry, nak, seen;
	logic [2:0] mode;
	logic [7:0] q;
	int n_fail = 0;
	int tests_run = 0;
	hsm_row_s rows [6] = '{'{8'h01, 8'h00, 8'h00}, '{8'h01, 8'h39, 8'h01},
		'{8'h01, 8'h46, 8'h46}, '{8'h01, 8'h07, 8'h07},
		'{8'h05, 8'hff, 8'h00}, '{8'h00, 8'hff, 8'h20}};
	hsm_regs #(.BEMF_CYCLES(20), .RETRY_CYCLES(16)) u_dut (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda),
		.o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_trigger_input_pin(trig),
		.i_overtemp(ot), .i_overcurrent(oc), .i_ev(ev), .o_go(go),
		.o_cancel(cancel), .o_standby(standby), .o_mode(mode),
		.o_playback_abort(abort), .o_shutdown(shutdown), .o_retry(retry));
	hsm_host #(.ADR(DEV_ADDR_DEFAULT)) u_host (
		.i_clk(i_clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
	////////////////////////////////////////////////////////////////////////
	// 250 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	// compare and report a mismatch
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
		u_host.rd(a, q);
		chk(nm, e, q);
	endtask : rdc
	// hold reset low for 20 cycles
	task automatic rst();
		i_rst_n = 1'b0;
		u_host.cy(20);
		i_rst_n = 1'b1;
		u_host.cy(4);
	endtask : rst
	// watch a one-cycle pulse for n cycles
	task automatic watch(input int n, ref logic p);
		seen = 1'b0;
		repeat (n) begin
			u_host.cy(1);
			seen |= p;
		end
	endtask : watch
	task automatic end_sim();
		if (n_fail == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////////////
	// hang guard: the tests need about 22k cycles, allow 40k
	initial begin
		#160000;
		n_fail++;
		end_sim();
	end
	// main sequence
	initial begin
		i_rst_n = 1'b0;
		trig = 1'b0;
		ot = 1'b0;
		oc = 1'b0;
		ev = '0;
		rst();
		foreach (rows[i]) begin
			u_host.wr(rows[i].a, rows[i].d, nak);
			chk("ack", 8'h00, {7'h0, nak});
			rdc(rows[i].a, rows[i].r, "readback");
			if (rows[i].a == 8'h01) begin
				chk("pins", {4'h0, rows[i].r[6], rows[i].r[2:0]}, {4'h0, standby, mode});
			end
		end
		rst();
		chk("rst_pins", 8'h40, {1'b0, standby, 3'h0, mode});
		chk("sda_drive", 8'h00, {7'h0, sda_o});
		rdc(8'h01, 8'h40, "rst_mode");
		rdc(8'h00, 8'h20, "rst_status");
		ot = 1'b1;
		u_host.cy(10);
		chk("ot_shut", 8'h01, {7'h0, shutdown});
		ot = 1'b0;
		rdc(8'h00, 8'h22, "ot_set");
		rdc(8'h00, 8'h20, "ot_clr");
		oc = 1'b1;
		watch(40, retry);
		chk("retry", 8'h01, {7'h0, seen});
		oc = 1'b0;
		rdc(8'h00, 8'h21, "oc_set");
		rdc(8'h00, 8'h20, "oc_clr");
		for (int n = 15; n <= 25; n += 10) begin
			ev.bemf_zero = 1'b1;
			u_host.cy(n);
			ev.bemf_zero = 1'b0;
			rdc(8'h00, (n > 20) ? 8'h24 : 8'h20, "fb_erm");
		end
		ev.lra_mode = 1'b1;
		ev.lock_lost = 1'b1;
		u_host.cy(1);
		ev.lock_lost = 1'b0;
		rdc(8'h00, 8'h24, "fb_lra");
		rdc(8'h00, 8'h20, "fb_clr");
		for (int i = 0; i < 4; i++) begin
			u_host.wr(8'h01, (i > 1) ? 8'h07 : 8'h06, nak);
			u_host.wr(ADDR_FIRE, 8'h01, nak);
			chk("fire", 8'h01, {7'h0, go});
			ev.routine_fail = ~i[0];
			ev.routine_done = 1'b1;
			u_host.cy(1);
			ev = '0;
			u_host.cy(2);
			chk("go_clr", 8'h00, {7'h0, go});
			rdc(8'h00, {4'h2, ~i[0], 3'h0}, "result");
		end
		u_host.wr(ADDR_FIRE, 8'h01, nak);
		fork
			u_host.wr(ADDR_FIRE, 8'h00, nak);
			watch(470, cancel);
		join
		chk("fire_cancel", 8'h02, {6'h0, seen, go});
		rdc(8'h00, 8'h20, "res_clr");
		u_host.wr(8'h01, 8'h01, nak);
		trig = 1'b1;
		u_host.cy(6);
		chk("edge_go", 8'h01, {7'h0, go});
		trig = 1'b0;
		u_host.cy(6);
		trig = 1'b1;
		watch(8, cancel);
		chk("cancel", 8'h02, {6'h0, seen, go});
		trig = 1'b0;
		u_host.cy(6);
		trig = 1'b1;
		u_host.cy(6);
		fork
			u_host.wr(8'h01, 8'h80, nak);
			watch(470, abort);
		join
		chk("abort", 8'h01, {7'h0, seen});
		chk("full_rst", 8'h40, {go, standby, 3'h0, mode});
		rdc(8'h01, 8'h40, "self_clr");
		end_sim();
	end
endmodule : testbench
